// [verilog/fwsac_fault_bank.sv]
// Fault, warning, pin mask and AC diagnostic control register bank
// Notes on behaviour
// - Fault one bit 4 shows clock fault
// - Fault one bits 3,2 show overvoltage
// - Fault one bits 1,0 show undervoltage
// - Fault two bit 4 shows global shutdown
// - Fault two bits 3..0 channel shutdowns
// - Warning bit 5 shows logic power-on reset
// - Warning bit 4 shows global thermal warning
// - Warning bits 3..0 channel thermal warnings
// - Mask bit 7 inhibits overcurrent on fault pin
// - Mask bit 6 inhibits shutdown on fault pin
// - Mask bits 5,4 inhibit under/overvoltage
// - Mask bit 3 inhibits DC fault reporting
// - Mask bit 2 inhibits current-limit reporting
// - Mask bit 1 inhibits clipping on warn pin
// - Mask bit 0 inhibits thermal warning reporting
// - Bits 7,5 select diag gain 1 or 4
// - Control one bits 3..0 enable channels
// - Control two bit 7 enables loopback
// - Control two bit 4 selects 32/64 cycles
// - Current field 00=10mA, 01=19mA, others reserved
// - Writing clear-fault bit clears latched faults
`timescale 1ns/100ps
`include "fwsac_defines.svh"
module fwsac_fault_bank (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // Register port from the serial control port
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire fwsac_pkg::fwsac_byte_t reg_wdata_in,
  output fwsac_pkg::fwsac_byte_t reg_rdata_out,
  // Fault and warning conditions
  input wire logic clock_fault_in,
  input wire logic power_stage_supply_over_in,
  input wire logic battery_supply_over_in,
  input wire logic power_stage_supply_under_in,
  input wire logic battery_supply_under_in,
  input wire logic thermal_shutdown_in,
  input wire logic [3:0] chan_thermal_shutdown_in,
  input wire logic thermal_warning_in,
  input wire logic [3:0] chan_thermal_warning_in,
  input wire logic overcurrent_in,
  input wire logic dc_offset_in,
  input wire logic current_limit_in,
  input wire logic clipping_in,
  // Report pins
  output logic fault_pin_out,
  output logic warning_pin_out,
  // AC diagnostic controls
  output logic pair_a_diag_gain_out,
  output logic pair_b_diag_gain_out,
  output logic [3:0] chan_ac_diag_enable_out,
  output logic ac_diag_loop_path_out,
  output logic [6:0] ac_diag_measure_cycles_out,
  output fwsac_pkg::fwsac_current_t ac_diag_test_current_out,
  output logic ac_diag_current_reserved_out
);
  import fwsac_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Latched fault and power-on flags
  logic clear_fault;
  logic [4:0] fault_one_set;
  logic [4:0] fault_one_flags;
  logic [4:0] fault_two_set;
  logic [4:0] fault_two_flags;
  logic por_q;
  logic por_d;

  assign clear_fault = reg_wr_in && (reg_addr_in == `FWSAC_OFS_MISC_CTRL)
                       && reg_wdata_in[`FWSAC_BIT_CLEAR_FAULT];

  assign fault_one_set = {clock_fault_in, power_stage_supply_over_in, battery_supply_over_in,
                          power_stage_supply_under_in, battery_supply_under_in};
  assign fault_two_set = {thermal_shutdown_in, chan_thermal_shutdown_in};

  fwsac_sticky_flags #(.WIDTH(5)) u_fault_one (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .set_in(fault_one_set),
    .clear_in(clear_fault),
    .flags_out(fault_one_flags)
  );

  fwsac_sticky_flags #(.WIDTH(5)) u_fault_two (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .set_in(fault_two_set),
    .clear_in(clear_fault),
    .flags_out(fault_two_flags)
  );

  // Power-on flag is set by reset itself and cleared by a clear-fault write
  always_comb begin
    por_d = por_q & ~clear_fault;
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      por_q <= 1'b1;
    end else begin
      por_q <= por_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Writable registers
  fwsac_byte_t pin_mask_q;
  fwsac_byte_t pin_mask_d;
  fwsac_byte_t ac_one_q;
  fwsac_byte_t ac_one_d;
  fwsac_byte_t ac_two_q;
  fwsac_byte_t ac_two_d;

  always_comb begin
    pin_mask_d = pin_mask_q;
    ac_one_d = ac_one_q;
    ac_two_d = ac_two_q;
    if (reg_wr_in) begin
      case (reg_addr_in)
        `FWSAC_OFS_PIN_MASK: pin_mask_d = reg_wdata_in;
        `FWSAC_OFS_AC_CTRL_ONE: ac_one_d = reg_wdata_in & `FWSAC_MASK_AC_CTRL_ONE;
        `FWSAC_OFS_AC_CTRL_TWO: ac_two_d = reg_wdata_in & `FWSAC_MASK_AC_CTRL_TWO;
        default: pin_mask_d = pin_mask_q;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_mask_q <= `FWSAC_RST_PIN_MASK;
      ac_one_q <= `FWSAC_RST_AC_CTRL_ONE;
      ac_two_q <= `FWSAC_RST_AC_CTRL_TWO;
    end else begin
      pin_mask_q <= pin_mask_d;
      ac_one_q <= ac_one_d;
      ac_two_q <= ac_two_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data
  fwsac_byte_t rdata_q;
  fwsac_byte_t rdata_d;

  always_comb begin
    case (reg_addr_in)
      `FWSAC_OFS_FAULT_ONE: rdata_d = {3'h0, fault_one_flags};
      `FWSAC_OFS_FAULT_TWO: rdata_d = {3'h0, fault_two_flags};
      `FWSAC_OFS_WARNING: rdata_d = {2'h0, por_q, thermal_warning_in,
                                     chan_thermal_warning_in};
      `FWSAC_OFS_PIN_MASK: rdata_d = pin_mask_q;
      `FWSAC_OFS_AC_CTRL_ONE: rdata_d = ac_one_q;
      `FWSAC_OFS_AC_CTRL_TWO: rdata_d = ac_two_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_out = rdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // Report pins
  logic fault_pin_q;
  logic fault_pin_d;
  logic warn_pin_q;
  logic warn_pin_d;

  always_comb begin
    fault_pin_d = 1'b0;
    if (!pin_mask_q[`FWSAC_BIT_INH_OC] && overcurrent_in) begin
      fault_pin_d = 1'b1;
    end
    if (!pin_mask_q[`FWSAC_BIT_INH_SHUTDOWN] && (|fault_two_flags)) begin
      fault_pin_d = 1'b1;
    end
    if (!pin_mask_q[`FWSAC_BIT_INH_UNDER]
        && (fault_one_flags[`FWSAC_BIT_POWER_STAGE_SUPPLY_UNDER] || fault_one_flags[`FWSAC_BIT_VBAT_UNDER])) begin
      fault_pin_d = 1'b1;
    end
    if (!pin_mask_q[`FWSAC_BIT_INH_OVER]
        && (fault_one_flags[`FWSAC_BIT_POWER_STAGE_SUPPLY_OVER] || fault_one_flags[`FWSAC_BIT_VBAT_OVER])) begin
      fault_pin_d = 1'b1;
    end
    if (!pin_mask_q[`FWSAC_BIT_INH_DC] && dc_offset_in) begin
      fault_pin_d = 1'b1;
    end
    if (!pin_mask_q[`FWSAC_BIT_INH_ILIMIT] && current_limit_in) begin
      fault_pin_d = 1'b1;
    end
    if (fault_one_flags[`FWSAC_BIT_CLOCK_FAULT]) begin
      fault_pin_d = 1'b1;
    end
    warn_pin_d = (!pin_mask_q[`FWSAC_BIT_INH_CLIP] && clipping_in)
                 || (!pin_mask_q[`FWSAC_BIT_INH_WARNING]
                     && (thermal_warning_in || (|chan_thermal_warning_in)));
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fault_pin_q <= 1'b0;
      warn_pin_q <= 1'b0;
    end else begin
      fault_pin_q <= fault_pin_d;
      warn_pin_q <= warn_pin_d;
    end
  end

  assign fault_pin_out = fault_pin_q;
  assign warning_pin_out = warn_pin_q;

  //////////////////////////////////////////////////////////////////////////////
  // AC diagnostic controls
  assign pair_a_diag_gain_out = ac_one_q[`FWSAC_BIT_PAIR_A_GAIN];
  assign pair_b_diag_gain_out = ac_one_q[`FWSAC_BIT_PAIR_B_GAIN];
  assign chan_ac_diag_enable_out = ac_one_q[3:0];
  assign ac_diag_loop_path_out = ac_two_q[`FWSAC_BIT_LOOP_PATH];
  assign ac_diag_measure_cycles_out = ac_two_q[`FWSAC_BIT_MEASURE_LEN]
                                      ? `FWSAC_MEASURE_LONG : `FWSAC_MEASURE_SHORT;
  assign ac_diag_test_current_out =
    fwsac_current_t'(ac_two_q[`FWSAC_BIT_CURRENT_HI:`FWSAC_BIT_CURRENT_LO]);
  assign ac_diag_current_reserved_out = ac_two_q[`FWSAC_BIT_CURRENT_HI];
endmodule // fwsac_fault_bank

// [verilog/fwsac_defines.svh]
// Register offsets, field positions, reset values and timing counts for the fault bank
`ifndef FWSAC_DEFINES_SVH
`define FWSAC_DEFINES_SVH

`define FWSAC_OFS_FAULT_ONE 8'h11
`define FWSAC_OFS_FAULT_TWO 8'h12
`define FWSAC_OFS_WARNING 8'h13
`define FWSAC_OFS_PIN_MASK 8'h14
`define FWSAC_OFS_AC_CTRL_ONE 8'h15
`define FWSAC_OFS_AC_CTRL_TWO 8'h16
`define FWSAC_OFS_MISC_CTRL 8'h21

`define FWSAC_RST_FAULT_ONE 8'h00
`define FWSAC_RST_FAULT_TWO 8'h00
`define FWSAC_RST_WARNING 8'h20
`define FWSAC_RST_PIN_MASK 8'h00
`define FWSAC_RST_AC_CTRL_ONE 8'h00
`define FWSAC_RST_AC_CTRL_TWO 8'h00

`define FWSAC_BIT_CLOCK_FAULT 4
`define FWSAC_BIT_POWER_STAGE_SUPPLY_OVER 3
`define FWSAC_BIT_VBAT_OVER 2
`define FWSAC_BIT_POWER_STAGE_SUPPLY_UNDER 1
`define FWSAC_BIT_VBAT_UNDER 0
`define FWSAC_BIT_GLOBAL_SHUTDOWN 4
`define FWSAC_BIT_LOGIC_POR 5
`define FWSAC_BIT_GLOBAL_WARNING 4

`define FWSAC_BIT_INH_OC 7
`define FWSAC_BIT_INH_SHUTDOWN 6
`define FWSAC_BIT_INH_UNDER 5
`define FWSAC_BIT_INH_OVER 4
`define FWSAC_BIT_INH_DC 3
`define FWSAC_BIT_INH_ILIMIT 2
`define FWSAC_BIT_INH_CLIP 1
`define FWSAC_BIT_INH_WARNING 0

`define FWSAC_BIT_PAIR_A_GAIN 7
`define FWSAC_BIT_PAIR_B_GAIN 5
`define FWSAC_BIT_LOOP_PATH 7
`define FWSAC_BIT_MEASURE_LEN 4
`define FWSAC_BIT_CURRENT_HI 3
`define FWSAC_BIT_CURRENT_LO 2
`define FWSAC_BIT_CLEAR_FAULT 7

`define FWSAC_MASK_AC_CTRL_ONE 8'hAF
`define FWSAC_MASK_AC_CTRL_TWO 8'h9C

`define FWSAC_MEASURE_SHORT 7'h20
`define FWSAC_MEASURE_LONG 7'h40

`endif

// [verilog/fwsac_pkg.sv]
// Types shared by the fault and warning bank
package fwsac_pkg;
  typedef logic [7:0] fwsac_byte_t;
  typedef enum logic [1:0] {
    FWSAC_CUR_10MA,
    FWSAC_CUR_19MA,
    FWSAC_CUR_RSVD_A,
    FWSAC_CUR_RSVD_B
  } fwsac_current_t;
endpackage

// [verilog/fwsac_sticky_flags.sv]
// Sticky event flags with set winning over clear
`timescale 1ns/100ps
module fwsac_sticky_flags #(
  parameter int WIDTH = 5
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // Events and clear
  input wire logic [WIDTH-1:0] set_in,
  input wire logic clear_in,
  // Held flags
  output logic [WIDTH-1:0] flags_out
);
  logic [WIDTH-1:0] flags_q;
  logic [WIDTH-1:0] flags_d;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_flag
      always_comb begin
        flags_d[i] = set_in[i] | (flags_q[i] & ~clear_in);
      end
    end
  endgenerate

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags_out = flags_q;
endmodule // fwsac_sticky_flags

// [tb/fwsac_fault_bank_props.sv]
// Concurrent checks on the fault bank ports
`timescale 1ns/100ps
module fwsac_fault_bank_chk (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // Register port
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire fwsac_pkg::fwsac_byte_t reg_wdata_in,
  input wire fwsac_pkg::fwsac_byte_t reg_rdata_out,
  // Conditions and outputs
  input wire logic clock_fault_in,
  input wire logic thermal_warning_in,
  input wire logic [3:0] chan_thermal_warning_in,
  input wire logic fault_pin_out,
  input wire logic pair_a_diag_gain_out,
  input wire logic pair_b_diag_gain_out,
  input wire logic [3:0] chan_ac_diag_enable_out,
  input wire logic ac_diag_loop_path_out,
  input wire logic [6:0] ac_diag_measure_cycles_out,
  input wire fwsac_pkg::fwsac_current_t ac_diag_test_current_out
);
  import fwsac_pkg::*;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  logic w15;
  logic w16;
  assign w15 = reg_wr_in && reg_addr_in == 8'h15;
  assign w16 = reg_wr_in && reg_addr_in == 8'h16;
  property p_gain;
    w15 |=> {pair_a_diag_gain_out, pair_b_diag_gain_out} == $past({reg_wdata_in[7], reg_wdata_in[5]});
  endproperty
  a_gain: assert property (p_gain) else $error("diag gain wrong");
  property p_en;
    w15 |=> chan_ac_diag_enable_out == $past(reg_wdata_in[3:0]);
  endproperty
  a_en: assert property (p_en) else $error("channel enable wrong");
  property p_loop;
    w16 |=> ac_diag_loop_path_out == $past(reg_wdata_in[7]);
  endproperty
  a_loop: assert property (p_loop) else $error("loop path wrong");
  property p_len;
    w16 |=> ac_diag_measure_cycles_out == ($past(reg_wdata_in[4]) ? 7'h40 : 7'h20);
  endproperty
  a_len: assert property (p_len) else $error("measure length wrong");
  property p_cur;
    w16 |=> ac_diag_test_current_out == $past(reg_wdata_in[3:2]);
  endproperty
  a_cur: assert property (p_cur) else $error("test current wrong");
  property p_clk;
    clock_fault_in |-> ##2 fault_pin_out;
  endproperty
  a_clk: assert property (p_clk) else $error("clock fault not on pin");
  property p_warn;
    $past(reg_addr_in) == 8'h13 |-> reg_rdata_out[4:0] ==
      $past({thermal_warning_in, chan_thermal_warning_in});
  endproperty
  a_warn: assert property (p_warn) else $error("warning read wrong");
  property p_unmap;
    !(reg_addr_in inside {[8'h11:8'h16]}) |=> reg_rdata_out == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule // fwsac_fault_bank_chk
bind fwsac_fault_bank fwsac_fault_bank_chk u_chk (.mclk_in, .reset_n_in, .reg_wr_in,
  .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .clock_fault_in, .thermal_warning_in,
  .chan_thermal_warning_in, .fault_pin_out, .pair_a_diag_gain_out, .pair_b_diag_gain_out,
  .chan_ac_diag_enable_out, .ac_diag_loop_path_out, .ac_diag_measure_cycles_out,
  .ac_diag_test_current_out);

// [tb/fwsac_fault_bank_tb.sv]
// Self-checking bench for the fault and warning bank
`timescale 1ns/100ps
module fwsac_fault_bank_tb;
  import fwsac_pkg::*;
  logic mclk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic reg_wr_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  fwsac_byte_t reg_wdata_in = 8'h00;
  fwsac_byte_t reg_rdata_out;
  logic [4:0] f1 = 5'h00;
  logic [4:0] f2 = 5'h00;
  logic [4:0] tw = 5'h00;
  logic [3:0] lv = 4'h0;
  logic fault_pin_out, warning_pin_out, ga, gb, loop_o, res_o;
  logic [3:0] en_o;
  logic [6:0] cyc_o;
  fwsac_current_t cur_o;
  int miscompares = 0;
  int n_tests = 0;
  always #50 mclk_in = ~mclk_in;
  fwsac_fault_bank dut (.mclk_in, .reset_n_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in,
    .reg_rdata_out, .clock_fault_in(f1[4]), .power_stage_supply_over_in(f1[3]),
    .battery_supply_over_in(f1[2]), .power_stage_supply_under_in(f1[1]),
    .battery_supply_under_in(f1[0]), .thermal_shutdown_in(f2[4]),
    .chan_thermal_shutdown_in(f2[3:0]), .thermal_warning_in(tw[4]),
    .chan_thermal_warning_in(tw[3:0]), .overcurrent_in(lv[3]), .dc_offset_in(lv[2]),
    .current_limit_in(lv[1]), .clipping_in(lv[0]), .fault_pin_out, .warning_pin_out,
    .pair_a_diag_gain_out(ga), .pair_b_diag_gain_out(gb), .chan_ac_diag_enable_out(en_o),
    .ac_diag_loop_path_out(loop_o), .ac_diag_measure_cycles_out(cyc_o),
    .ac_diag_test_current_out(cur_o), .ac_diag_current_reserved_out(res_o));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    reg_wr_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(negedge mclk_in);
    reg_wr_in = 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk_in);
    reg_addr_in = a;
    @(negedge mclk_in);
    check(reg_rdata_out, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdc(8'h11, 8'h00);
    rdc(8'h12, 8'h00);
    rdc(8'h13, 8'h20);
    rdc(8'h14, 8'h00);
    rdc(8'h15, 8'h00);
    rdc(8'h16, 8'h00);
    check({1'b0, cyc_o}, 8'h20);
    rdc(8'h30, 8'h00);
  endtask
  task automatic t_ctrl;
    wr(8'h15, 8'hFF);
    rdc(8'h15, 8'hAF);
    check({ga, gb, 2'h0, en_o}, 8'hCF);
    wr(8'h16, 8'hF7);
    rdc(8'h16, 8'h94);
    check({loop_o, cyc_o}, 8'hC0);
    check({5'h00, res_o, cur_o}, 8'h01);
    // Only the two legal current codes are ever programmed
    for (int c = 0; c < 2; c++) begin
      wr(8'h16, 8'(c * 4));
      check({loop_o, cyc_o}, 8'h20);
      check({5'h00, res_o, cur_o}, 8'(c));
    end
    wr(8'h15, 8'h00);
    check({ga, gb, 2'h0, en_o}, 8'h00);
    wr(8'h11, 8'hFF);
    rdc(8'h11, 8'h00);
  endtask
  task automatic t_faults;
    for (int i = 0; i < 5; i++) begin
      @(negedge mclk_in);
      f1 = 5'(1 << i);
      f2 = 5'(1 << i);
      @(negedge mclk_in);
      f1 = 5'h00;
      f2 = 5'h00;
      rdc(8'h11, 8'(1 << i));
      rdc(8'h12, 8'(1 << i));
      check({7'h00, fault_pin_out}, 8'h01);
      wr(8'h21, 8'h7F);
      rdc(8'h11, 8'(1 << i));
      wr(8'h21, 8'h80);
      rdc(8'h11, 8'h00);
      rdc(8'h12, 8'h00);
      check({7'h00, fault_pin_out}, 8'h00);
    end
    // Event and clear land on the same edge: the event must survive
    @(negedge mclk_in);
    f1 = 5'h01;
    reg_wr_in = 1'b1;
    reg_addr_in = 8'h21;
    reg_wdata_in = 8'h80;
    @(negedge mclk_in);
    reg_wr_in = 1'b0;
    f1 = 5'h00;
    rdc(8'h11, 8'h01);
    wr(8'h21, 8'h80);
    rdc(8'h11, 8'h00);
    rdc(8'h13, 8'h00);
    tw = 5'h15;
    rdc(8'h13, 8'h15);
    check({7'h00, warning_pin_out}, 8'h01);
    tw = 5'h00;
  endtask
  task automatic t_mask;
    for (int k = 0; k < 8; k++) begin
      @(negedge mclk_in);
      case (k)
        7: lv = 4'h8;
        6: f2 = 5'h10;
        5: f1 = 5'h01;
        4: f1 = 5'h04;
        3: lv = 4'h4;
        2: lv = 4'h2;
        1: lv = 4'h1;
        default: tw = 5'h10;
      endcase
      wr(8'h14, 8'h00);
      rdc(8'h14, 8'h00);
      check({7'h00, k > 1 ? fault_pin_out : warning_pin_out}, 8'h01);
      wr(8'h14, 8'(1 << k));
      rdc(8'h14, 8'(1 << k));
      check({7'h00, k > 1 ? fault_pin_out : warning_pin_out}, 8'h00);
      lv = 4'h0;
      f1 = 5'h00;
      f2 = 5'h00;
      tw = 5'h00;
      wr(8'h21, 8'h80);
    end
  endtask
  task automatic results;
    if (miscompares == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk_in);
    @(negedge mclk_in);
    reset_n_in = 1'b1;
    t_reset;
    t_ctrl;
    t_faults;
    t_mask;
    results;
  end
endmodule // fwsac_fault_bank_tb
